//--- esrb_pkg.sv
/*
 * Shared constants for the embedded synchronous RAM block: block kinds, port modes,
 * register offsets, field positions, reset values and the word-index helper.
 * Assumes every file names its items as esrb_pkg::name, without an import.
 */
`default_nettype none
package esrb_pkg;
	// Physical block kinds and their geometry.
	localparam logic [1:0] KIND_SMALL = 2'h0;
	localparam logic [1:0] KIND_MID   = 2'h1;
	localparam logic [1:0] KIND_LARGE = 2'h2;
	localparam int SMALL_WORDS = 32;
	localparam int SMALL_WIDTH = 18;
	localparam int MID_WORDS   = 128;
	localparam int MID_WIDTH   = 36;
	localparam int LARGE_WORDS = 4096;
	localparam int LARGE_WIDTH = 144;

	// Port arrangement of the array.
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_SDP    = 2'h1,
		MODE_TDP    = 2'h2
	} esrb_mode_t;

	// Register offsets on the software port.
	localparam logic [7:0] REG_CFG  = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;

	// Configuration fields.
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_OREG_A   = 2;
	localparam int CFG_OREG_B   = 3;
	localparam int CFG_RDW_OLD  = 4;
	localparam int CFG_SPLIT    = 5;
	localparam int CFG_FLOW     = 6;
	localparam int CFG_SH_A_LSB = 8;
	localparam int CFG_SH_B_LSB = 10;
	localparam int CFG_ROM_LOCK = 12;
	localparam logic [31:0] CFG_RESET = 32'h0000_000D;
	localparam logic [1:0]  MAX_SHIFT = 2'h2;

	// Status fields.
	localparam int ST_COLL     = 0;
	localparam int ST_SPCONF   = 1;
	localparam int ST_WBLK     = 2;
	localparam int ST_LOCK     = 3;
	localparam int ST_KIND_LSB = 4;

	// Physical word index of a narrow-unit address for a width shift.
	function automatic int unsigned word_idx(input logic [31:0] addr, input logic [1:0] sh);
		return int'(addr >> sh);
	endfunction
endpackage
`default_nettype wire

//--- esrb_port_if.sv
/*
 * One registered access port of the RAM array: write strobe, address, write data,
 * width shift and read data. Driven by the control logic, consumed by the array.
 */
`timescale 1ns/1ps
`default_nettype none
interface esrb_port_if #(
	parameter int AW = 9,
	parameter int W  = 36
);
	logic          we;
	logic [AW-1:0] addr;
	logic [W-1:0]  wdata;
	logic [1:0]    sh;
	logic [W-1:0]  rdata;
	modport ctrl  (output we, output addr, output wdata, output sh, input rdata);
	modport array (input we, input addr, input wdata, input sh, output rdata);
endinterface
`default_nettype wire

//--- esrb_array.sv
/*
 * Storage array with two ports of independent width. Writes land on the rising edge
 * from the already registered strobe; reads are combinational from the registered address.
 * Assumes the control logic gates strobes for mode, lock and split.
 */
`timescale 1ns/1ps
`default_nettype none
module esrb_array #(
	parameter int WORDS = 128,
	parameter int WIDTH = 36,
	parameter int AW    = 9
) (
	input wire logic      clk,
	esrb_port_if.array    pa,
	esrb_port_if.array    pb
);
	localparam int WA = $clog2(WORDS);

	logic [WIDTH-1:0] mem [WORDS];

	// Lane of the narrow unit inside its physical word.
	function automatic int lane_of(input logic [AW-1:0] a, input logic [1:0] sh);
		case (sh)
			2'h0: return 0;
			2'h1: return int'(a[0]);
			default: return int'(a[1:0]);
		endcase
	endfunction

	// Replaces one lane of a stored word with new narrow data.
	function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old, input logic [WIDTH-1:0] d,
	                                           input int lane, input logic [1:0] sh);
		int w;
		logic [WIDTH-1:0] r;
		w = WIDTH >> sh;
		r = old;
		for (int i = 0; i < WIDTH; i++) begin
			if (i / w == lane) begin
				r[i] = d[i % w];
			end
		end
		return r;
	endfunction

	// Pulls one lane out of a stored word into the low bits.
	function automatic logic [WIDTH-1:0] extract(input logic [WIDTH-1:0] word, input int lane, input logic [1:0] sh);
		int w;
		logic [WIDTH-1:0] r;
		w = WIDTH >> sh;
		r = '0;
		for (int j = 0; j < WIDTH; j++) begin
			if (j < w) begin
				r[j] = word[lane * w + j];
			end
		end
		return r;
	endfunction

	logic [WA-1:0] word_a;
	logic [WA-1:0] word_b;

	assign word_a = WA'(esrb_pkg::word_idx(32'(pa.addr), pa.sh));
	assign word_b = WA'(esrb_pkg::word_idx(32'(pb.addr), pb.sh));

	// Port A is written last, so it owns a word that both ports write at once.
	always_ff @(posedge clk) begin
		if (pb.we) begin
			mem[word_b] <= merge(mem[word_b], pb.wdata, lane_of(pb.addr, pb.sh), pb.sh);
		end
		if (pa.we) begin
			mem[word_a] <= merge(mem[word_a], pa.wdata, lane_of(pa.addr, pa.sh), pa.sh);
		end
	end

	// Reads show the stored word before any write of this cycle lands.
	assign pa.rdata = extract(mem[word_a], lane_of(pa.addr, pa.sh), pa.sh);
	assign pb.rdata = extract(mem[word_b], lane_of(pb.addr, pb.sh), pb.sh);
endmodule
`default_nettype wire

//--- esrb_outreg.sv
/*
 * Read-data output stage: an optional pipeline register with a clear, or a
 * straight path from the array when bypassed. Assumes clear and enable on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module esrb_outreg #(
	parameter int W       = 36,
	parameter bit CLEARED = 1'b1
) (
	input wire logic         clk,
	input wire logic         rst,
	input wire logic         clr,
	input wire logic         ce,
	input wire logic         use_reg,
	input wire logic [W-1:0] d,
	output logic     [W-1:0] q
);
	logic [W-1:0] q_ff;

	generate
		if (CLEARED) begin : g_clr
			// Cleared at power-up and on demand.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					q_ff <= '0;
				end else if (clr) begin
					q_ff <= '0;
				end else if (ce) begin
					q_ff <= d;
				end
			end
		end else begin : g_noclr
			// No power-up value; only the explicit clear acts.
			always_ff @(posedge clk) begin
				if (clr) begin
					q_ff <= '0;
				end else if (ce) begin
					q_ff <= d;
				end
			end
		end
	endgenerate

	// The bypass hands the array output straight through.
	assign q = use_reg ? q_ff : d;
endmodule
`default_nettype wire

//--- esrb_top.sv
/*
 * Embedded synchronous RAM block: input registers, self-timed write strobes,
 * port modes, mixed widths, output stages, read-during-write handling and a small
 * register file. Assumes user logic on clk drives both ports and the register port.
 */
`timescale 1ns/1ps
`default_nettype none
module esrb_top #(
	parameter logic [1:0] KIND  = esrb_pkg::KIND_MID,
	parameter int          WORDS = esrb_pkg::MID_WORDS,
	parameter int          WIDTH = esrb_pkg::MID_WIDTH,
	parameter int          AW    = $clog2(WORDS) + 2
) (
	input wire logic             clk,
	input wire logic             rst,
	input wire logic [7:0]       reg_addr,
	input wire logic [31:0]      reg_wdata,
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	output logic     [31:0]      reg_rdata,
	input wire logic             in_clear,
	input wire logic             out_clear,
	input wire logic             a_re,
	input wire logic             a_we,
	input wire logic [AW-1:0]    a_addr,
	input wire logic [WIDTH-1:0] a_wdata,
	output logic     [WIDTH-1:0] a_q,
	input wire logic             b_re,
	input wire logic             b_we,
	input wire logic [AW-1:0]    b_addr,
	input wire logic [WIDTH-1:0] b_wdata,
	output logic     [WIDTH-1:0] b_q
);
	localparam bit IS_LARGE = (KIND == esrb_pkg::KIND_LARGE);
	localparam int WA       = $clog2(WORDS);

	esrb_port_if #(.AW(AW), .W(WIDTH)) pa ();
	esrb_port_if #(.AW(AW), .W(WIDTH)) pb ();

	logic [31:0]      cfg_ff;
	logic             lock_ff;
	logic [2:0]       stat_ff;
	logic [31:0]      reg_rdata_ff;
	logic             a_we_ff, a_re_ff, b_we_ff, b_re_ff;
	logic [AW-1:0]    a_addr_ff, b_addr_ff, b_addr_neg_ff;
	logic             b_re_neg_ff;
	logic [WIDTH-1:0] a_wdata_ff, b_wdata_ff;
	logic             a_wrote_ff, b_wrote_ff;
	logic             in_clr, split, flow, single_a, rdw_old;
	logic [1:0]       mode, sh_a, sh_b;
	logic             a_wr_ok, a_rd_ok, b_wr_ok, b_rd_ok, b_rd_req;
	logic             coll_a, coll_b, sp_conf, wr_blk;
	logic [WIDTH-1:0] d_a, d_b;
	logic [31:0]      nxt_cfg;

	// Forces the top word-address bit so each split half stays in its own half.
	function automatic logic [AW-1:0] half_addr(input logic [AW-1:0] a, input logic [1:0] sh, input logic hi);
		logic [AW-1:0] r;
		r = a;
		r[WA - 1 + int'(sh)] = hi;
		return r;
	endfunction

	// Configuration decode; split only exists on mid blocks, flow-through not on large.
	assign mode     = cfg_ff[esrb_pkg::CFG_MODE_LSB +: 2];
	assign split    = cfg_ff[esrb_pkg::CFG_SPLIT];
	assign flow     = cfg_ff[esrb_pkg::CFG_FLOW] && mode == esrb_pkg::MODE_SDP;
	assign sh_a     = cfg_ff[esrb_pkg::CFG_SH_A_LSB +: 2];
	assign sh_b     = cfg_ff[esrb_pkg::CFG_SH_B_LSB +: 2];
	assign rdw_old  = cfg_ff[esrb_pkg::CFG_RDW_OLD] && !IS_LARGE;
	assign single_a = (mode == esrb_pkg::MODE_SINGLE) || split;
	assign in_clr   = in_clear && !IS_LARGE;

	// Clamps a software write to what this block kind supports.
	always_comb begin
		nxt_cfg = reg_wdata & 32'h0000_0F7F;
		if (KIND == esrb_pkg::KIND_SMALL && reg_wdata[1:0] != esrb_pkg::MODE_SINGLE) begin
			nxt_cfg[1:0] = esrb_pkg::MODE_SDP;
		end
		if (reg_wdata[1:0] == 2'h3) begin
			nxt_cfg[1:0] = esrb_pkg::MODE_SDP;
		end
		if (KIND != esrb_pkg::KIND_MID || reg_wdata[1:0] != esrb_pkg::MODE_SINGLE) begin
			nxt_cfg[esrb_pkg::CFG_SPLIT] = 1'b0;
		end
		if (IS_LARGE) begin
			nxt_cfg[esrb_pkg::CFG_FLOW] = 1'b0;
		end
		if (reg_wdata[esrb_pkg::CFG_SH_A_LSB +: 2] > esrb_pkg::MAX_SHIFT) begin
			nxt_cfg[esrb_pkg::CFG_SH_A_LSB +: 2] = esrb_pkg::MAX_SHIFT;
		end
		if (reg_wdata[esrb_pkg::CFG_SH_B_LSB +: 2] > esrb_pkg::MAX_SHIFT) begin
			nxt_cfg[esrb_pkg::CFG_SH_B_LSB +: 2] = esrb_pkg::MAX_SHIFT;
		end
	end

	// Configuration register; the lock is set-only and leaves only with reset.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_ff  <= esrb_pkg::CFG_RESET;
			lock_ff <= 1'b0;
		end else if (reg_wr && reg_addr == esrb_pkg::REG_CFG) begin
			cfg_ff  <= nxt_cfg;
			lock_ff <= lock_ff | reg_wdata[esrb_pkg::CFG_ROM_LOCK];
		end
	end

	// Sticky status: write one to clear, a new event in the same cycle wins.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stat_ff <= '0;
		end else begin
			stat_ff[esrb_pkg::ST_COLL]   <= coll_a | coll_b |
				(stat_ff[esrb_pkg::ST_COLL] & ~(reg_wr && reg_addr == esrb_pkg::REG_STAT &&
				reg_wdata[esrb_pkg::ST_COLL]));
			stat_ff[esrb_pkg::ST_SPCONF] <= sp_conf |
				(stat_ff[esrb_pkg::ST_SPCONF] & ~(reg_wr && reg_addr == esrb_pkg::REG_STAT &&
				reg_wdata[esrb_pkg::ST_SPCONF]));
			stat_ff[esrb_pkg::ST_WBLK]   <= wr_blk |
				(stat_ff[esrb_pkg::ST_WBLK] & ~(reg_wr && reg_addr == esrb_pkg::REG_STAT &&
				reg_wdata[esrb_pkg::ST_WBLK]));
		end
	end

	// Read data stands in the cycle after the strobe; unmapped offsets read zero.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata_ff <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				esrb_pkg::REG_CFG: reg_rdata_ff <= cfg_ff | (32'(lock_ff) << esrb_pkg::CFG_ROM_LOCK);
				esrb_pkg::REG_STAT: reg_rdata_ff <= {24'h00_0000, 2'h0, KIND, lock_ff, stat_ff[2:0]};
				default: reg_rdata_ff <= '0;
			endcase
		end else begin
			reg_rdata_ff <= '0;
		end
	end
	assign reg_rdata = reg_rdata_ff;

	// Input registers for both ports; the large block has no input clear.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			a_we_ff    <= 1'b0;
			a_re_ff    <= 1'b0;
			b_we_ff    <= 1'b0;
			b_re_ff    <= 1'b0;
			a_addr_ff  <= '0;
			b_addr_ff  <= '0;
			a_wdata_ff <= '0;
			b_wdata_ff <= '0;
		end else if (in_clr) begin
			a_we_ff    <= 1'b0;
			a_re_ff    <= 1'b0;
			b_we_ff    <= 1'b0;
			b_re_ff    <= 1'b0;
			a_addr_ff  <= '0;
			b_addr_ff  <= '0;
			a_wdata_ff <= '0;
			b_wdata_ff <= '0;
		end else begin
			a_we_ff <= a_we;
			a_re_ff <= a_re;
			b_we_ff <= b_we;
			b_re_ff <= b_re;
			if (a_re || a_we) begin
				a_addr_ff <= a_addr;
			end
			if (b_re || b_we) begin
				b_addr_ff <= b_addr;
			end
			if (a_we) begin
				a_wdata_ff <= a_wdata;
			end
			if (b_we) begin
				b_wdata_ff <= b_wdata;
			end
		end
	end

	// Flow-through read address and enable taken on the falling edge of the same clock.
	always_ff @(negedge clk or posedge rst) begin
		if (rst) begin
			b_addr_neg_ff <= '0;
			b_re_neg_ff   <= 1'b0;
		end else if (flow && b_re) begin
			b_addr_neg_ff <= b_addr;
			b_re_neg_ff   <= 1'b1;
		end else begin
			b_re_neg_ff   <= 1'b0;
		end
	end

	// Self-timed write strobes and read qualifiers from the registered inputs.
	assign b_rd_req = flow ? b_re_neg_ff : b_re_ff;
	assign a_wr_ok  = a_we_ff && !lock_ff;
	assign a_rd_ok  = a_re_ff && mode != esrb_pkg::MODE_SDP && !(single_a && a_we_ff);
	assign b_wr_ok  = b_we_ff && !lock_ff && (mode == esrb_pkg::MODE_TDP || split);
	assign b_rd_ok  = b_rd_req && (mode != esrb_pkg::MODE_SINGLE || split) && !(split && b_we_ff);
	assign sp_conf  = (single_a && a_we_ff && a_re_ff) || (split && b_we_ff && b_re_ff);
	assign wr_blk   = lock_ff && (a_we_ff || b_we_ff);

	// Mixed-port same-word collisions.
	assign coll_b = b_rd_ok && a_wr_ok && !split &&
		esrb_pkg::word_idx(32'(pa.addr), sh_a) == esrb_pkg::word_idx(32'(pb.addr), sh_b);
	assign coll_a = a_rd_ok && b_wr_ok && !split &&
		esrb_pkg::word_idx(32'(pa.addr), sh_a) == esrb_pkg::word_idx(32'(pb.addr), sh_b);

	// Drive the array ports.
	assign pa.we    = a_wr_ok;
	assign pa.addr  = split ? half_addr(a_addr_ff, sh_a, 1'b0) : a_addr_ff;
	assign pa.wdata = a_wdata_ff;
	assign pa.sh    = sh_a;
	assign pb.we    = b_wr_ok;
	assign pb.addr  = split ? half_addr(b_addr_ff, sh_b, 1'b1) : (flow ? b_addr_neg_ff : b_addr_ff);
	assign pb.wdata = b_wdata_ff;
	assign pb.sh    = sh_b;

	// A collision without old-data mode returns the all-ones filler.
	assign d_a = (coll_a && !rdw_old) ? '1 : pa.rdata;
	assign d_b = (coll_b && !rdw_old) ? '1 : pb.rdata;

	// Remembers a single-port write so the output stage picks up the new word.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			a_wrote_ff <= 1'b0;
			b_wrote_ff <= 1'b0;
		end else begin
			a_wrote_ff <= a_wr_ok && single_a;
			b_wrote_ff <= b_wr_ok && split;
		end
	end

	esrb_array #(.WORDS(WORDS), .WIDTH(WIDTH), .AW(AW)) u_array (
		.clk (clk),
		.pa  (pa),
		.pb  (pb)
	);

	esrb_outreg #(.W(WIDTH), .CLEARED(!IS_LARGE)) u_out_a (
		.clk     (clk),
		.rst     (rst),
		.clr     (out_clear),
		.ce      (a_rd_ok || a_wrote_ff),
		.use_reg (cfg_ff[esrb_pkg::CFG_OREG_A]),
		.d       (d_a),
		.q       (a_q)
	);

	esrb_outreg #(.W(WIDTH), .CLEARED(!IS_LARGE)) u_out_b (
		.clk     (clk),
		.rst     (rst),
		.clr     (out_clear),
		.ce      (b_rd_ok || b_wrote_ff),
		.use_reg (cfg_ff[esrb_pkg::CFG_OREG_B] && !flow),
		.d       (d_b),
		.q       (b_q)
	);

	// Checks on the control path.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	in_reg_a: assert property ((a_re || a_we) && !in_clr |=> a_addr_ff == $past(a_addr))
		else $error("port A address not captured");
	wr_strobe_a: assert property (pa.we |-> $past(a_we) && !lock_ff)
		else $error("write strobe without a registered request");
	sp_exclusive_a: assert property (single_a && a_we_ff && a_re_ff |->
		!a_rd_ok ##1 stat_ff[esrb_pkg::ST_SPCONF])
		else $error("single-port read and write together");
	sp_visible_a: assert property (a_wr_ok && single_a && cfg_ff[esrb_pkg::CFG_OREG_A] && !out_clear
		##1 !out_clear && !in_clr |=> a_q == $past(pa.rdata))
		else $error("registered output missed written data");
	bypass_q_a: assert property (a_wr_ok && single_a && !cfg_ff[esrb_pkg::CFG_OREG_A]
		&& sh_a == 2'h0 |=> pa.addr != $past(pa.addr) || a_q == $past(pa.wdata))
		else $error("bypassed output missed written data");
	rdw_fill_a: assert property (coll_b && !rdw_old && cfg_ff[esrb_pkg::CFG_OREG_B] && !flow
		&& !out_clear |=> b_q == '1)
		else $error("collision filler not returned");
	rom_lock_a: assert property (lock_ff && (a_we_ff || b_we_ff) |->
		(!pa.we && !pb.we) ##1 stat_ff[esrb_pkg::ST_WBLK])
		else $error("write while locked");
	kind_mode_a: assert property (KIND == esrb_pkg::KIND_SMALL |-> mode != esrb_pkg::MODE_TDP)
		else $error("true dual-port on a small block");
	split_half_a: assert property (split |-> pa.addr[WA - 1 + int'(sh_a)] == 1'b0 &&
		pb.addr[WA - 1 + int'(sh_b)] == 1'b1)
		else $error("split half escaped");
	flow_addr_a: assert property (flow && b_re && !split |-> pb.addr == b_addr && b_rd_ok)
		else $error("flow-through address not taken");
	in_clear_a: assert property (in_clear && !IS_LARGE |=> !a_we_ff && !b_we_ff)
		else $error("input clear ignored");

	tdp_two_writes_c: cover property (pa.we && pb.we);
	collision_c: cover property (coll_b);
	single_write_read_c: cover property (a_wr_ok && single_a ##1 a_rd_ok);
	flow_read_c: cover property (flow && b_rd_ok);
endmodule
`default_nettype wire

//--- esrb_fabric.sv
/*
 * Fabric-side user logic that drives both ports of the RAM block one request at a time.
 * Assumes the bench calls its tasks and that clk is the block's only port clock.
 */
`timescale 1ns/1ps
`default_nettype none
module esrb_fabric #(
	parameter int AW = 9,
	parameter int W  = 36
) (
	input wire logic      clk,
	output logic          a_re,
	output logic          a_we,
	output logic [AW-1:0] a_addr,
	output logic [W-1:0]  a_wdata,
	output logic          b_re,
	output logic          b_we,
	output logic [AW-1:0] b_addr,
	output logic [W-1:0]  b_wdata
);
	// Nothing is requested at time zero.
	initial begin
		{a_re, a_we, b_re, b_we} = 4'h0;
		{a_addr, b_addr} = '0;
		{a_wdata, b_wdata} = '0;
	end

	// Requests change just after a rising edge and hold a full cycle, so a falling-edge capture sees them settled.
	task automatic drive(input logic [3:0] f, input logic [AW-1:0] aa, input logic [W-1:0] ad,
		input logic [AW-1:0] ba, input logic [W-1:0] bd);
		@(posedge clk);
		{a_we, a_re, b_we, b_re} <= f;
		a_addr <= aa;
		a_wdata <= ad;
		b_addr <= ba;
		b_wdata <= bd;
	endtask

	// Drops the strobes; after a lock the bench still requests one write, which the block must block.
	task automatic idle();
		@(posedge clk);
		{a_we, a_re, b_we, b_re} <= 4'h0;
	endtask
endmodule
`default_nettype wire

//--- embedded_sync_ram_block_test.sv
/*
 * Self-checking bench for the RAM block: register port tasks, port operations and checks.
 * Assumes a mid-sized block and the fabric model driving both memory ports.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module embedded_sync_ram_block_test;
	localparam int AW = 9;
	localparam int W  = 36;
	logic          clk;
	logic          rst;
	logic          reg_wr;
	logic          reg_rd;
	logic          in_clear;
	logic          out_clear;
	logic [7:0]    reg_addr;
	logic [31:0]   reg_wdata;
	logic [31:0]   reg_rdata;
	logic [31:0]   st;
	logic          a_re;
	logic          a_we;
	logic          b_re;
	logic          b_we;
	logic [AW-1:0] a_addr;
	logic [AW-1:0] b_addr;
	logic [W-1:0]  a_wdata;
	logic [W-1:0]  b_wdata;
	logic [W-1:0]  a_q;
	logic [W-1:0]  b_q;
	int            miscompares = 0;
	int            total_checks = 0;
	int            cycles = 0;

	// Clock at 50 MHz.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	esrb_top #(.KIND(esrb_pkg::KIND_MID), .WORDS(128), .WIDTH(W), .AW(AW)) dut (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_clear(in_clear), .out_clear(out_clear),
		.a_re(a_re), .a_we(a_we), .a_addr(a_addr), .a_wdata(a_wdata), .a_q(a_q),
		.b_re(b_re), .b_we(b_we), .b_addr(b_addr), .b_wdata(b_wdata), .b_q(b_q));

	esrb_fabric #(.AW(AW), .W(W)) fab (
		.clk(clk), .a_re(a_re), .a_we(a_we), .a_addr(a_addr), .a_wdata(a_wdata),
		.b_re(b_re), .b_we(b_we), .b_addr(b_addr), .b_wdata(b_wdata));

	// Prints the verdict and stops the run.
	task automatic end_of_test();
		if (miscompares == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// One-cycle register write.
	task automatic reg_w(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// One-cycle register read; data is taken in the cycle after the strobe.
	task automatic reg_r(input logic [7:0] ad, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// One port cycle on both ports, then strobes drop.
	task automatic op(input logic [3:0] f, input logic [AW-1:0] aa, input logic [W-1:0] ad,
		input logic [AW-1:0] ba, input logic [W-1:0] bd);
		fab.drive(f, aa, ad, ba, bd);
		fab.idle();
	endtask

	// Waits n rising edges and lets their updates settle.
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Cuts a hung run short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			miscompares++;
			end_of_test();
		end
	end

	// Main sequence.
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, in_clear, out_clear} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wt(1);
		`CHK("a_q", 36'h0_0000_0000, a_q)
		`CHK("b_q", 36'h0_0000_0000, b_q)
		reg_r(8'h00, st);
		`CHK("cfg", 32'h0000_000D, st)
		reg_r(8'h04, st);
		`CHK("kind", esrb_pkg::KIND_MID, st[5:4])
		reg_r(8'h08, st);
		`CHK("unmapped", 32'h0000_0000, st)
		// Simple dual-port: read one word while writing another.
		op(4'h8, 9'h003, 36'h1_1111_1111, 9'h000, 36'h0_0000_0000);
		op(4'h9, 9'h004, 36'h2_2222_2222, 9'h003, 36'h0_0000_0000);
		wt(1);
		`CHK("sdp rd", 36'h1_1111_1111, b_q)
		op(4'h1, 9'h000, 36'h0_0000_0000, 9'h004, 36'h0_0000_0000);
		wt(1);
		`CHK("sdp rd2", 36'h2_2222_2222, b_q)
		// Same-word collision gives filler, then old data.
		op(4'h9, 9'h003, 36'h3_3333_3333, 9'h003, 36'h0_0000_0000);
		wt(1);
		`CHK("filler", 36'hF_FFFF_FFFF, b_q)
		reg_r(8'h04, st);
		`CHK("coll", 1'b1, st[0])
		reg_w(8'h00, 32'h0000_001D);
		op(4'h9, 9'h003, 36'h4_4444_4444, 9'h003, 36'h0_0000_0000);
		wt(1);
		`CHK("old", 36'h3_3333_3333, b_q)
		// Output register clear.
		@(posedge clk);
		out_clear <= 1'b1;
		@(posedge clk);
		out_clear <= 1'b0;
		#1;
		`CHK("oclr", 36'h0_0000_0000, b_q)
		// Input clear drops a write request before it reaches the array.
		fab.drive(4'h8, 9'h003, 36'hE_EEEE_EEEE, 9'h000, 36'h0_0000_0000);
		in_clear <= 1'b1;
		fab.idle();
		in_clear <= 1'b0;
		op(4'h1, 9'h000, 36'h0_0000_0000, 9'h003, 36'h0_0000_0000);
		wt(1);
		`CHK("iclr", 36'h4_4444_4444, b_q)
		// True dual-port: two writes, then two reads.
		reg_w(8'h00, 32'h0000_000E);
		op(4'hA, 9'h00A, 36'h5_5555_5555, 9'h014, 36'h6_6666_6666);
		op(4'h5, 9'h014, 36'h0_0000_0000, 9'h00A, 36'h0_0000_0000);
		wt(1);
		`CHK("tdp a", 36'h6_6666_6666, a_q)
		`CHK("tdp b", 36'h5_5555_5555, b_q)
		// Mixed widths: full word in on port A, quarter lanes out on port B.
		reg_w(8'h00, 32'h0000_080D);
		op(4'h8, 9'h002, 36'h7_6543_2109, 9'h000, 36'h0_0000_0000);
		for (int i = 0; i < 4; i++) begin
			op(4'h1, 9'h000, 36'h0_0000_0000, 9'h008 + 9'(i), 36'h0_0000_0000);
			wt(1);
			`CHK("lane", 36'h7_6543_2109 >> (9 * i) & 36'h0_0000_01FF, b_q & 36'h0_0000_01FF)
		end
		// Quarter lane in on port A, full word out on port B.
		reg_w(8'h00, 32'h0000_020D);
		op(4'h8, 9'h051, 36'h0_0000_01AB, 9'h000, 36'h0_0000_0000);
		op(4'h1, 9'h000, 36'h0_0000_0000, 9'h014, 36'h0_0000_0000);
		wt(1);
		`CHK("narrow wr", 36'h6_6667_5666, b_q)
		// Flow-through read is ready before the next rising edge.
		reg_w(8'h00, 32'h0000_004D);
		fab.drive(4'h1, 9'h000, 36'h0_0000_0000, 9'h002, 36'h0_0000_0000);
		#12;
		`CHK("flow", 36'h7_6543_2109, b_q)
		fab.idle();
		// Single port, bypassed then registered output.
		reg_w(8'h00, 32'h0000_0000);
		op(4'h8, 9'h006, 36'h8_8888_8888, 9'h000, 36'h0_0000_0000);
		wt(1);
		`CHK("sp byp", 36'h8_8888_8888, a_q)
		reg_w(8'h00, 32'h0000_0004);
		op(4'h8, 9'h006, 36'h9_9999_9999, 9'h000, 36'h0_0000_0000);
		wt(2);
		`CHK("sp reg", 36'h9_9999_9999, a_q)
		op(4'hC, 9'h006, 36'hA_AAAA_AAAA, 9'h000, 36'h0_0000_0000);
		reg_r(8'h04, st);
		`CHK("sp conf", 1'b1, st[1])
		// Split into two single-port halves.
		reg_w(8'h00, 32'h0000_0020);
		op(4'hA, 9'h001, 36'hB_BBBB_BBBB, 9'h001, 36'hC_CCCC_CCCC);
		op(4'h5, 9'h001, 36'h0_0000_0000, 9'h001, 36'h0_0000_0000);
		wt(0);
		`CHK("split a", 36'hB_BBBB_BBBB, a_q)
		`CHK("split b", 36'hC_CCCC_CCCC, b_q)
		// Locked block ignores writes.
		reg_w(8'h00, 32'h0000_100D);
		op(4'h8, 9'h003, 36'hD_DDDD_DDDD, 9'h000, 36'h0_0000_0000);
		op(4'h1, 9'h000, 36'h0_0000_0000, 9'h003, 36'h0_0000_0000);
		wt(1);
		`CHK("lock rd", 36'h4_4444_4444, b_q)
		reg_r(8'h04, st);
		`CHK("lock st", 2'b11, st[3:2])
		reg_w(8'h04, 32'h0000_0007);
		reg_r(8'h04, st);
		`CHK("w1c", 4'h8, st[3:0])
		end_of_test();
	end
endmodule
`default_nettype wire
